/* src/rcb_pkg.sv */
// rcb_pkg: register map, field positions, reset values and carrier types
// for the reference clock generators and peripheral bus dividers.
// assumes a 32-bit plain register port with one-cycle read latency.
package rcb_pkg;

  localparam int unsigned REF_COUNT   = 4;
  localparam int unsigned BUS_COUNT   = 7;
  localparam int unsigned ADDR_WIDTH  = 8;
  localparam int unsigned DATA_WIDTH  = 32;
  localparam int unsigned NDIV_WIDTH  = 15;
  localparam int unsigned FRAC_WIDTH  = 9;
  localparam int unsigned BDIV_WIDTH  = 7;
  localparam int unsigned SRC_WIDTH   = 4;
  localparam int unsigned SRC_COUNT   = 9;

  // register map: byte addresses
  localparam logic [ADDR_WIDTH-1:0] REF_CTRL_BASE = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] REF_TRIM_BASE = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] REF_STRIDE    = 8'h10;
  localparam logic [ADDR_WIDTH-1:0] BUS_DIV_BASE  = 8'h40;
  localparam logic [ADDR_WIDTH-1:0] BUS_STRIDE    = 8'h04;

  // control register fields
  localparam int unsigned CTL_NDIV_LSB   = 16;
  localparam int unsigned CTL_ENABLE     = 15;
  localparam int unsigned CTL_IDLE_STOP  = 13;
  localparam int unsigned CTL_PIN_DRIVE  = 12;
  localparam int unsigned CTL_SLEEP_RUN  = 11;
  localparam int unsigned CTL_SWITCH_REQ = 9;
  localparam int unsigned CTL_ACTIVE     = 8;
  localparam int unsigned CTL_SRC_LSB    = 0;
  localparam int unsigned TRIM_FRAC_LSB  = 23;

  // bus divider fields
  localparam int unsigned BUS_ENABLE     = 15;
  localparam int unsigned BUS_READY      = 11;
  localparam int unsigned BUS_DIV_LSB    = 0;

  // reference sources
  localparam logic [SRC_WIDTH-1:0] SRC_SYSTEM_CLOCK = 4'h0;
  localparam logic [SRC_WIDTH-1:0] SRC_BUS_ONE      = 4'h1;

  // bus divider reset values
  localparam logic [BDIV_WIDTH-1:0] BDIV_RESET_LOW  = 7'h01;
  localparam logic [BDIV_WIDTH-1:0] BDIV_RESET_SIX  = 7'h03;
  localparam logic [BDIV_WIDTH-1:0] BDIV_RESET_CPU  = 7'h00;
  localparam int unsigned           BUS_SIX_INDEX   = 5;
  localparam int unsigned           BUS_CPU_INDEX   = 6;
  localparam int unsigned           BUS_ONE_INDEX   = 0;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } rcb_bus_req_type;

  typedef struct packed {
    logic                  power_idle;
    logic                  power_sleep;
  } rcb_power_type;

  typedef struct packed {
    logic [NDIV_WIDTH-1:0] ndiv;
    logic                  enable;
    logic                  idle_stop;
    logic                  pin_drive;
    logic                  sleep_run;
    logic                  switch_req;
    logic                  active;
    logic [SRC_WIDTH-1:0]  src;
    logic [FRAC_WIDTH-1:0] frac;
  } rcb_ref_regs_type;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_SWITCH = 2'b01
  } rcb_bus_state_type;

endpackage : rcb_pkg

/* src/rcb_top.sv */
// rcb_top: four fractional reference clock generators and seven
// peripheral bus clock dividers behind a plain register port.
// assumes source clock levels arrive synchronous to clk_i; outputs are
// clock-enable style levels toggled in the clk_i domain.
//
// Functional notes
// - four reference generators and seven bus dividers, each with own registers
// - integer divider in control 30:16; zero bypasses division
// - control bit 15 enables the reference generator
// - idle-stop bit 13 halts generator in Idle, else it runs
// - pin drive bit 12 drives generated clock onto output pin
// - sleep-run bit 11 keeps output in Sleep; ignored for sources 0 and 1
// - switch request bit 9 set by software, cleared by hardware when done
// - read-only bit 8 shows reference clock request active
// - source select 3:0 picks one of nine sources; 9 to 15 reserved
// - trim bits 31:23 add M/512 to integer divider N
// - with generator enabled, trim writes wait for switch request
// - trim has no effect when N is zero
// - output is source divided by two times N plus M/512
// - fractional ratios steal source cycles to match average frequency
// - bus divider bit 15 enables or gates the bus clock
// - ready bit 11 low during divisor change; divisor writes then rejected
// - seven-bit divisor divides system clock by value plus one
// - reset divisors: buses one to five 1, six 3, seven 0
// - bus one and seven clocks never disabled; zero writes ignored
// - bus seven divisor read-only, fixed at zero
`timescale 1ns/10ps
module rcb_top
  import rcb_pkg::*;
#(
  parameter int unsigned NREF = REF_COUNT,
  parameter int unsigned NBUS = BUS_COUNT
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // register port
  input  wire rcb_bus_req_type        bus_req_i,
  output logic [DATA_WIDTH-1:0]       bus_rdata_o,
  // power mode and clock sources
  input  wire rcb_power_type          power_i,
  input  wire logic [SRC_COUNT-1:0]   src_level_i,
  // generated clocks
  output logic [NREF-1:0]             ref_clock_o,
  output logic [NREF-1:0]             ref_clock_output_pin_o,
  output logic [NREF-1:0]             ref_clock_output_pin_oe_n_o,
  output logic [NBUS-1:0]             peripheral_bus_clock_o
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [DATA_WIDTH-1:0]                 rdata;
    rcb_ref_regs_type [NREF-1:0]           gen;
    logic [NREF-1:0][FRAC_WIDTH-1:0]       frac_pend;
    logic [NREF-1:0][NDIV_WIDTH-1:0]       cnt;
    logic [NREF-1:0][FRAC_WIDTH-1:0]       acc;
    logic [NREF-1:0]                       phase;
    logic [NREF-1:0]                       src_last;
    logic [NREF-1:0]                       out;
    logic [NREF-1:0]                       pin;
    logic [NREF-1:0]                       pin_oe_n;
    logic [NBUS-1:0]                       bus_on;
    logic [NBUS-1:0][BDIV_WIDTH-1:0]       bus_div;
    logic [NBUS-1:0][BDIV_WIDTH-1:0]       bus_pend;
    rcb_bus_state_type [NBUS-1:0]          bus_st;
    logic [NBUS-1:0][BDIV_WIDTH-1:0]       bus_cnt;
    logic [NBUS-1:0]                       bus_clk;
  } rcb_state_type;

  rcb_state_type st;
  rcb_state_type next_st;

  // decode helpers: address match for write and read paths, reset divisor per bus
  function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a,
                                   input logic [ADDR_WIDTH-1:0] base,
                                   input logic [ADDR_WIDTH-1:0] stride,
                                   input int unsigned           idx);
    return a == ADDR_WIDTH'(base + stride * ADDR_WIDTH'(idx));
  endfunction

  function automatic logic [BDIV_WIDTH-1:0] bus_reset_div(input int unsigned idx);
    if (idx == BUS_CPU_INDEX) begin
      return BDIV_RESET_CPU;
    end else if (idx == BUS_SIX_INDEX) begin
      return BDIV_RESET_SIX;
    end
    return BDIV_RESET_LOW;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic                  run;
    logic                  src_lvl;
    logic                  src_edge;
    logic [FRAC_WIDTH:0]   acc_sum;
    logic                  steal;
    next_st  = st;
    run      = 1'b0;
    src_lvl  = 1'b0;
    src_edge = 1'b0;
    acc_sum  = '0;
    steal    = 1'b0;
    next_st.rdata = '0;

    // reference generators
    for (int i = 0; i < NREF; i++) begin
      // pending trim applied only through the switch request
      if (st.gen[i].switch_req) begin
        next_st.gen[i].frac       = st.frac_pend[i];
        next_st.gen[i].switch_req = 1'b0;
        next_st.cnt[i]            = '0;
        next_st.acc[i]            = '0;
        next_st.phase[i]          = 1'b0;
      end
      // register writes; software keeps enable equal to active here
      if (bus_req_i.wr && addr_is(bus_req_i.addr, REF_CTRL_BASE, REF_STRIDE, i)) begin
        next_st.gen[i].ndiv       = bus_req_i.wdata[CTL_NDIV_LSB +: NDIV_WIDTH];
        next_st.gen[i].enable     = bus_req_i.wdata[CTL_ENABLE];
        next_st.gen[i].idle_stop  = bus_req_i.wdata[CTL_IDLE_STOP];
        next_st.gen[i].pin_drive  = bus_req_i.wdata[CTL_PIN_DRIVE];
        next_st.gen[i].sleep_run  = bus_req_i.wdata[CTL_SLEEP_RUN];
        next_st.gen[i].src        = bus_req_i.wdata[CTL_SRC_LSB +: SRC_WIDTH];
        // software only sets the request; a new set beats the hardware clear
        next_st.gen[i].switch_req = next_st.gen[i].switch_req
                                    | bus_req_i.wdata[CTL_SWITCH_REQ];
      end
      if (bus_req_i.wr && addr_is(bus_req_i.addr, REF_TRIM_BASE, REF_STRIDE, i)) begin
        next_st.frac_pend[i] = bus_req_i.wdata[TRIM_FRAC_LSB +: FRAC_WIDTH];
        if (!st.gen[i].enable) begin
          next_st.gen[i].frac = bus_req_i.wdata[TRIM_FRAC_LSB +: FRAC_WIDTH];
        end
      end

      // power gating: sources 0 and 1 stop in sleep regardless
      run = st.gen[i].enable
            && !(power_i.power_idle && st.gen[i].idle_stop)
            && !(power_i.power_sleep && (!st.gen[i].sleep_run
                 || st.gen[i].src == SRC_SYSTEM_CLOCK
                 || st.gen[i].src == SRC_BUS_ONE));
      next_st.gen[i].active = run;

      // source pick; reserved codes give a still source
      if (32'(st.gen[i].src) < SRC_COUNT) begin
        src_lvl = src_level_i[st.gen[i].src];
      end else begin
        src_lvl = 1'b0;
      end
      next_st.src_last[i] = src_lvl;
      src_edge = src_lvl && !st.src_last[i];

      // half-period count N plus M/512, cycle stealing via accumulator
      acc_sum = {1'b0, st.acc[i]} + {1'b0, st.gen[i].frac};
      steal   = acc_sum[FRAC_WIDTH] && (st.gen[i].ndiv != '0);
      if (!run) begin
        next_st.cnt[i]   = '0;
        next_st.out[i]   = 1'b0;
        next_st.phase[i] = 1'b0;
      end else if (st.gen[i].ndiv == '0) begin
        next_st.out[i] = src_lvl;
      end else if (src_edge) begin
        if (st.cnt[i] + NDIV_WIDTH'(1) >= st.gen[i].ndiv
            && !(steal && !st.phase[i])) begin
          next_st.cnt[i]   = '0;
          next_st.out[i]   = ~st.out[i];
          // steal flag spent; next carry may swallow again
          next_st.phase[i] = 1'b0;
          next_st.acc[i]   = acc_sum[FRAC_WIDTH-1:0];
        end else if (st.cnt[i] + NDIV_WIDTH'(1) >= st.gen[i].ndiv) begin
          // one extra source period swallowed for the fraction
          next_st.phase[i] = 1'b1;
        end else begin
          next_st.cnt[i] = st.cnt[i] + NDIV_WIDTH'(1);
        end
      end
      next_st.pin[i]      = st.gen[i].pin_drive ? st.out[i] : 1'b0;
      next_st.pin_oe_n[i] = ~st.gen[i].pin_drive;
    end

    // peripheral bus dividers
    for (int b = 0; b < NBUS; b++) begin
      if (bus_req_i.wr && addr_is(bus_req_i.addr, BUS_DIV_BASE, BUS_STRIDE, b)
          && b != BUS_CPU_INDEX) begin
        if (b != BUS_ONE_INDEX) begin
          next_st.bus_on[b] = bus_req_i.wdata[BUS_ENABLE];
        end
        if (st.bus_st[b] == BUS_IDLE
            && bus_req_i.wdata[BUS_DIV_LSB +: BDIV_WIDTH] != st.bus_div[b]) begin
          next_st.bus_pend[b] = bus_req_i.wdata[BUS_DIV_LSB +: BDIV_WIDTH];
          next_st.bus_st[b]   = BUS_SWITCH;
        end
      end
      // divisor changes at the end of the running period, hiding glitches
      if (st.bus_cnt[b] >= st.bus_div[b]) begin
        next_st.bus_cnt[b] = '0;
        if (st.bus_st[b] == BUS_SWITCH) begin
          next_st.bus_div[b] = st.bus_pend[b];
          next_st.bus_st[b]  = BUS_IDLE;
        end
      end else begin
        next_st.bus_cnt[b] = st.bus_cnt[b] + BDIV_WIDTH'(1);
      end
      // high for the first half of each divided period; div 1 follows enable
      next_st.bus_clk[b] = st.bus_on[b] &&
                           ((st.bus_div[b] == '0) ||
                            ({1'b0, next_st.bus_cnt[b]} <= ({1'b0, st.bus_div[b]} >> 1)));
    end

    // read path, data stands one cycle later
    if (bus_req_i.rd) begin
      for (int i = 0; i < NREF; i++) begin
        if (addr_is(bus_req_i.addr, REF_CTRL_BASE, REF_STRIDE, i)) begin
          next_st.rdata[CTL_NDIV_LSB +: NDIV_WIDTH] = st.gen[i].ndiv;
          next_st.rdata[CTL_ENABLE]     = st.gen[i].enable;
          next_st.rdata[CTL_IDLE_STOP]  = st.gen[i].idle_stop;
          next_st.rdata[CTL_PIN_DRIVE]  = st.gen[i].pin_drive;
          next_st.rdata[CTL_SLEEP_RUN]  = st.gen[i].sleep_run;
          next_st.rdata[CTL_SWITCH_REQ] = st.gen[i].switch_req;
          next_st.rdata[CTL_ACTIVE]     = st.gen[i].active;
          next_st.rdata[CTL_SRC_LSB +: SRC_WIDTH] = st.gen[i].src;
        end
        if (addr_is(bus_req_i.addr, REF_TRIM_BASE, REF_STRIDE, i)) begin
          next_st.rdata[TRIM_FRAC_LSB +: FRAC_WIDTH] = st.frac_pend[i];
        end
      end
      for (int b = 0; b < NBUS; b++) begin
        if (addr_is(bus_req_i.addr, BUS_DIV_BASE, BUS_STRIDE, b)) begin
          next_st.rdata[BUS_ENABLE] = st.bus_on[b];
          next_st.rdata[BUS_READY]  = (st.bus_st[b] == BUS_IDLE);
          next_st.rdata[BUS_DIV_LSB +: BDIV_WIDTH] = st.bus_div[b];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st <= '0;
      for (int b = 0; b < NBUS; b++) begin
        st.bus_on[b]   <= 1'b1;
        st.bus_div[b]  <= bus_reset_div(b);
        st.bus_pend[b] <= bus_reset_div(b);
        st.bus_st[b]   <= BUS_IDLE;
      end
      st.pin_oe_n <= '1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata_o                 = st.rdata;
  assign ref_clock_o                 = st.out;
  assign ref_clock_output_pin_o      = st.pin;
  assign ref_clock_output_pin_oe_n_o = st.pin_oe_n;
  assign peripheral_bus_clock_o      = st.bus_clk;

endmodule // rcb_top

/* testbench/rcb_top_props.sv */
// checker for rcb_top: read port framing, register read values, clock outputs
// assumes it is bound onto rcb_top and sees only that module's ports
`timescale 1ns/10ps
module rcb_top_props
  import rcb_pkg::*;
#(
  parameter int unsigned NREF = REF_COUNT,
  parameter int unsigned NBUS = BUS_COUNT
) (
  // clock, reset and register port
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  input wire rcb_bus_req_type       bus_req_i,
  input wire logic [DATA_WIDTH-1:0] bus_rdata_o,
  // power mode and sources
  input wire rcb_power_type         power_i,
  input wire logic [SRC_COUNT-1:0]  src_level_i,
  // generated clocks
  input wire logic [NREF-1:0]       ref_clock_o,
  input wire logic [NREF-1:0]       ref_clock_output_pin_o,
  input wire logic [NREF-1:0]       ref_clock_output_pin_oe_n_o,
  input wire logic [NBUS-1:0]       peripheral_bus_clock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////////
  // last request, kept so each read answer is tied to its address
  logic       rd_q;
  logic [7:0] ad_q;
  always_ff @(posedge clk_i) begin
    rd_q <= bus_req_i.rd;
    ad_q <= bus_req_i.addr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  rd_idle_zero_a: assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 32'h0)
    else $error("read data not zero outside read slot");
  pin_undriven_a: assert property ((ref_clock_output_pin_o & ref_clock_output_pin_oe_n_o) == '0)
    else $error("pin data high while pin not driven");
  cpu_clock_on_a: assert property ($past(rstn_i, 2) |-> peripheral_bus_clock_o[BUS_CPU_INDEX])
    else $error("cpu bus clock not following system clock");
  cpu_reg_fixed_a: assert property (rd_q && ad_q == 8'h58 |-> bus_rdata_o == 32'h0000_8800)
    else $error("cpu bus divider register not fixed");
  bus_one_on_a: assert property (rd_q && ad_q == 8'h40 |-> bus_rdata_o[15])
    else $error("bus one clock reads disabled");
  ctrl_unused_a: assert property (rd_q && ad_q[7:6] == 2'b00 && ad_q[3:0] == 4'h0
      |-> (bus_rdata_o & 32'h8000_44f0) == 32'h0)
    else $error("control unused bits not zero");
  trim_unused_a: assert property (rd_q && ad_q[7:6] == 2'b00 && ad_q[3:0] == 4'h4
      |-> bus_rdata_o[22:0] == 23'h0)
    else $error("trim unused bits not zero");
  bus_unused_a: assert property (rd_q && ad_q >= 8'h40 && ad_q <= 8'h58 && ad_q[1:0] == 2'b00
      |-> (bus_rdata_o & 32'hffff_7780) == 32'h0)
    else $error("bus divider unused bits not zero");
  unmapped_zero_a: assert property (rd_q && (ad_q > 8'h58 || (ad_q < 8'h40 && ad_q[3]))
      |-> bus_rdata_o == 32'h0)
    else $error("unmapped address read not zero");
endmodule // rcb_top_props

bind rcb_top rcb_top_props #(.NREF(NREF), .NBUS(NBUS)) u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
  .power_i(power_i), .src_level_i(src_level_i), .ref_clock_o(ref_clock_o),
  .ref_clock_output_pin_o(ref_clock_output_pin_o),
  .ref_clock_output_pin_oe_n_o(ref_clock_output_pin_oe_n_o),
  .peripheral_bus_clock_o(peripheral_bus_clock_o));

/* testbench/rcb_top_tb.sv */
// self-checking bench for rcb_top: registers, source select, dividers, power modes
// assumes the register map and one-cycle read latency of rcb_pkg
`timescale 1ns/10ps
module rcb_top_tb;
  import rcb_pkg::*;
  logic                 clk_i = 1'b0;
  logic                 rstn_i = 1'b0;
  rcb_bus_req_type      req = '0;
  rcb_power_type        pwr = '0;
  logic [SRC_COUNT-1:0] src = '0;
  logic [31:0]          rdata, d, w;
  logic [3:0]           rclk, pin, oe_n;
  logic [6:0]           bclk;
  logic [31:0]          cur [4];
  int                   sdiv [SRC_COUNT] = '{default: 0};
  int                   exp_div [7] = '{1, 1, 1, 1, 1, 3, 0};
  int                   n_fail = 0;
  int                   checks_done = 0;
  int                   pidx = 0;
  int                   dv, c;
  bit                   use_bus = 1'b0;
  bit                   use_pin = 1'b0;
  logic                 probe;
  assign probe = use_bus ? bclk[pidx] : (use_pin ? pin[pidx] : rclk[pidx]);

  rcb_top u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus_req_i(req), .bus_rdata_o(rdata),
    .power_i(pwr), .src_level_i(src), .ref_clock_o(rclk), .ref_clock_output_pin_o(pin),
    .ref_clock_output_pin_oe_n_o(oe_n), .peripheral_bus_clock_o(bclk));

  always #25 clk_i = ~clk_i;
  // source k has period 2*(k+1) cycles, so a wrong select shows as a wrong period
  always @(posedge clk_i) begin
    for (int k = 0; k < SRC_COUNT; k++) begin
      sdiv[k] <= (sdiv[k] == k) ? 0 : sdiv[k] + 1;
      if (sdiv[k] == k) src[k] <= ~src[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    chk(d, e);
  endtask
  // cycles spanned by k periods of probe, -1 if it never completes
  task automatic meas(input int k, input int lim, output int cyc);
    int   n;
    logic prev;
    n = -1;
    cyc = 0;
    prev = probe;
    for (int t = 0; t < lim && n < k; t++) begin
      @(negedge clk_i);
      if (probe && !prev) n++;
      if (n >= 0) cyc++;
      prev = probe;
    end
    cyc = (n < k) ? -1 : cyc - 1;
  endtask
  task automatic mchk(input int k, input int exp, input int tol);
    int got;
    meas(k, (exp < 0) ? 200 : 2 * exp + 40, got);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ron(input int i, input int n, input int m, input int s, input int bits);
    cur[i] = (n << 16) | 32'h8200 | bits | s;
    wr(8'(16 * i + 4), 32'(m << 23));
    wr(8'(16 * i), cur[i]);
    cur[i] = cur[i] & 32'hffff_fdff;
    repeat (2) @(posedge clk_i);
    rchk(8'(16 * i), cur[i] | 32'h100);
  endtask
  // source left untouched: changing it while active is not allowed
  task automatic roff(input int i);
    wr(8'(16 * i), cur[i] & 32'hffff_7fff);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wready(input int b);
    for (int t = 0; t < 300; t++) begin
      rd(8'(64 + 4 * b), d);
      if (d[11] === 1'b1) break;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  int cfg_src [5] = '{2, 2, 2, 2, 0};
  // last entry: sleep_run set but source 0 still stops in sleep
  int cfg_bit [5] = '{32'h2000, 0, 0, 32'h800, 32'h800};
  int cfg_pwr [5] = '{1, 1, 2, 2, 2};
  int cfg_run [5] = '{0, 6, 0, 6, 0};
  initial begin
    void'($urandom(37));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int b = 0; b < 7; b++) rchk(8'(64 + 4 * b), 32'h8800 | exp_div[b]);
    for (int i = 0; i < 4; i++) rchk(8'(16 * i), 32'h0);
    rchk(8'h5c, 32'h0);
    rchk(8'h08, 32'h0);
    wr(8'hfc, '1);
    rchk(8'hfc, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w = $urandom & 32'hffff_7dff;
      wr(8'(16 * i), w);
      rchk(8'(16 * i), w & 32'h7fff_380f);
      w = $urandom;
      wr(8'(16 * i + 4), w);
      rchk(8'(16 * i + 4), w & 32'hff80_0000);
      wr(8'(16 * i), 32'h0);
    end
    for (int s = 0; s <= 9; s++) begin
      pidx = s % 4;
      ron(s % 4, 0, 0, s, 32'h1000);
      chk({31'h0, oe_n[s % 4]}, 32'h0);
      mchk(3, (s < 9) ? 6 * (s + 1) : -1, 0);
      use_pin = 1'b1;
      mchk(3, (s < 9) ? 6 * (s + 1) : -1, 0);
      use_pin = 1'b0;
      roff(s % 4);
    end
    pidx = 1;
    ron(1, 2, 0, 1, 0);
    mchk(4, 64, 0);
    roff(1);
    pidx = 2;
    ron(2, 3, 256, 0, 0);
    mchk(32, 448, 4);
    wr(8'h24, 32'h0);
    mchk(32, 448, 4);
    wr(8'h20, cur[2] | 32'h200);
    repeat (4) @(posedge clk_i);
    rchk(8'h20, cur[2] | 32'h100);
    mchk(32, 384, 2);
    roff(2);
    ron(2, 0, 256, 0, 0);
    mchk(8, 16, 0);
    roff(2);
    pidx = 3;
    for (int j = 0; j < 5; j++) begin
      ron(3, 0, 0, cfg_src[j], cfg_bit[j]);
      chk({31'h0, oe_n[3]}, 32'h1);
      @(posedge clk_i);
      pwr <= '{power_idle: cfg_pwr[j] == 1, power_sleep: cfg_pwr[j] == 2};
      repeat (3) @(posedge clk_i);
      mchk(3, cfg_run[j] ? 3 * cfg_run[j] : -1, 0);
      @(posedge clk_i);
      pwr <= '0;
      repeat (3) @(posedge clk_i);
      roff(3);
    end
    use_bus = 1'b1;
    for (int b = 1; b < 6; b++) begin
      pidx = b;
      dv = $urandom_range(7);
      exp_div[b] = dv;
      wr(8'(64 + 4 * b), 32'h8000 | dv | ($urandom & 32'hffff_7f80));
      wready(b);
      rchk(8'(64 + 4 * b), 32'h8800 | dv);
      // divide by one holds the level high, so no edge is seen
      mchk(4, (dv > 0) ? 4 * (dv + 1) : -1, 0);
    end
    pidx = 2;
    wr(8'h48, 32'h807f);
    wready(2);
    mchk(2, 256, 0);
    meas(0, 300, c);
    wr(8'h48, 32'h8005);
    rd(8'h48, d);
    chk(d & 32'h800, 32'h0);
    wr(8'h48, 32'h8009);
    wready(2);
    rchk(8'h48, 32'h8805);
    wr(8'h48, 32'h5);
    rchk(8'h48, 32'h805);
    mchk(1, -1, 0);
    wr(8'h40, 32'h1);
    rchk(8'h40, 32'h8801);
    pidx = 0;
    mchk(4, 8, 0);
    wr(8'h58, 32'h7f);
    rchk(8'h58, 32'h8800);
    pidx = 6;
    mchk(1, -1, 0);
    give_verdict();
  end

  // watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    #(50 * 40000);
    n_fail++;
    give_verdict();
  end
endmodule // rcb_top_tb
